// [verilog/emtr_top.v]
// Encoder marker handling, roll-over, captures and event timer front end.
// Assumes filtered synchronous encoder levels and a simple register port.
// Operation
// - Marker reset: zero forward, limit reverse
// - Reset applied on next quadrature pulse
// - Later resets align to first reset edge
// - Index rising forward, falling reverse
// - No marker reset: wrap via count limit
// - Reset clears mode control bits
// - Index rising edge captures count
// - Index mode: capture on next pulse
// - Aux rising edge captures count
// - Aux mode: capture at directional edge
// - Captures 16-bit, read only, undefined start
// - Single marker: reset only on first
// - First marker sets status bit
// - Check count at marker if marker reset on, flag error
// - Keep counting; error clears on match
// - Status shows filtered A, B, Z, S
// - Timer ticks at clock over divider
// - Decimate pulses; zero means 256
// - Velocity event stores timer, reloads one
// - Direction bit set while incrementing
// - A leads B is forward; swap bit
`include "emtr_defs.vh"
module emtr_top
(
  // Clock and reset
  input wire clk_i,
  input wire rst_b_i,
  // Filtered encoder inputs
  input wire phase_a_in_i,
  input wire phase_b_in_i,
  input wire index_marker_in_i,
  input wire aux_marker_in_i,
  // Register port
  input wire [3:0] addr_i,
  input wire [15:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [15:0] rdata_o,
  // Events
  output wire count_error_o,
  output wire velocity_event_o
);
  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  reg [15:0] encoder_control, count_limit, position_count;
  reg [15:0] index_capture, aux_capture;
  reg [15:0] interval_clock_divider, edge_interval_timer, interval_hold;
  reg [7:0] edge_decimation;
  reg limit_written, a_q, b_q, dir_up, first_seen, count_err, err_pulse;
  reg reset_armed, icap_armed, align_valid;
  reg [1:0] align_code;
  // State of the marker-reset sequencer
  localparam ST_IDLE = 2'b01;
  localparam ST_ARMED = 2'b10;

  wire swap = encoder_control[`EMTR_C_SWAP];
  wire mrst_en = encoder_control[`EMTR_C_MRST];
  wire snm_en = encoder_control[`EMTR_C_SNM];
  wire chk_en = encoder_control[`EMTR_C_CHK];
  wire icm_en = encoder_control[`EMTR_C_ICM];
  wire acm_en = encoder_control[`EMTR_C_ACM];

  // ---------------------------------------------------------------
  // Quadrature decode
  // ---------------------------------------------------------------
  // Swap routes pins to counter inputs
  wire qa = swap ? phase_b_in_i : phase_a_in_i;
  wire qb = swap ? phase_a_in_i : phase_b_in_i;
  wire a_chg = qa ^ a_q;
  wire b_chg = qb ^ b_q;
  wire quad_pulse = a_chg ^ b_chg;
  // Forward when A leads B
  wire pulse_up = a_chg ? (qa ^ qb) : ~(qa ^ qb);
  // Edge code: bit1 selects B, bit0 new level
  wire [1:0] edge_code = a_chg ? {1'b0, qa} : {1'b1, qb};

  // Previous phase levels
  always @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      a_q <= 1'b0;
      b_q <= 1'b0;
    end
    else
    begin
      a_q <= qa;
      b_q <= qb;
    end
  end

  // ---------------------------------------------------------------
  // Marker edge detection
  // ---------------------------------------------------------------
  wire z_rise, z_fall, s_rise, s_fall;

  emtr_edge_det u_z_edge
  (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .level_i(index_marker_in_i), .rise_o(z_rise), .fall_o(z_fall)
  );

  emtr_edge_det u_s_edge
  (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .level_i(aux_marker_in_i), .rise_o(s_rise), .fall_o(s_fall)
  );

  // Marker recognised by direction
  wire z_mark = dir_up ? z_rise : z_fall;

  // ---------------------------------------------------------------
  // Marker reset sequencer
  // ---------------------------------------------------------------
  wire [1:0] rst_state = reset_armed ? ST_ARMED : ST_IDLE;
  // Reversed direction uses the opposite level of the same phase
  wire [1:0] want_code = pulse_up ? align_code : {align_code[1], ~align_code[0]};
  wire edge_ok = ~align_valid | (edge_code == want_code);
  // Single marker mode blocks resets once the first one has been applied
  wire reset_allowed = mrst_en & ~(snm_en & align_valid);
  reg do_reset;

  // Reset fires on qualifying pulse after marker
  always @*
  begin
    do_reset = 1'b0;
    case (rst_state)
      ST_IDLE: do_reset = 1'b0;
      ST_ARMED: do_reset = quad_pulse & edge_ok & reset_allowed;
      default: do_reset = 1'b0;
    endcase
  end

  // Arm on marker, align on first reset
  always @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      reset_armed <= 1'b0;
      align_valid <= 1'b0;
      align_code <= 2'b00;
    end
    else
    begin
      if (!mrst_en)
        reset_armed <= 1'b0;
      else if (z_mark)
        reset_armed <= 1'b1;
      else if (do_reset)
        reset_armed <= 1'b0;
      if (do_reset && !align_valid)
      begin
        align_valid <= 1'b1;
        align_code <= pulse_up ? edge_code : {edge_code[1], ~edge_code[0]};
      end
    end
  end

  // ---------------------------------------------------------------
  // Position counter
  // ---------------------------------------------------------------
  reg [15:0] next_position_count;

  // Marker reset, roll-over or plain count
  always @*
  begin
    next_position_count = position_count;
    if (quad_pulse)
    begin
      if (do_reset)
        next_position_count = pulse_up ? `EMTR_ZERO16 : count_limit;
      else if (pulse_up)
        next_position_count = (position_count == count_limit) ? `EMTR_ZERO16 :
          position_count + `EMTR_ONE16;
      else
        next_position_count = (position_count == `EMTR_ZERO16) ? count_limit :
          position_count - `EMTR_ONE16;
    end
  end

  // Counter and direction flag
  always @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      position_count <= `EMTR_ZERO16;
      dir_up <= 1'b1;
    end
    else
    begin
      position_count <= next_position_count;
      if (quad_pulse)
        dir_up <= pulse_up;
    end
  end

  // ---------------------------------------------------------------
  // Marker status and count check
  // ---------------------------------------------------------------
  wire [15:0] expect_val = dir_up ? `EMTR_ZERO16 : count_limit;

  // First marker and error flag
  always @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      first_seen <= 1'b0;
      count_err <= 1'b0;
      err_pulse <= 1'b0;
    end
    else
    begin
      err_pulse <= 1'b0;
      if (z_mark)
        first_seen <= 1'b1;
      if (z_mark && chk_en && mrst_en)
      begin
        count_err <= (position_count != expect_val);
        err_pulse <= (position_count != expect_val);
      end
    end
  end

  assign count_error_o = err_pulse;

  // ---------------------------------------------------------------
  // Capture registers
  // ---------------------------------------------------------------
  // Index capture armed by directional marker
  always @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      icap_armed <= 1'b0;
    else if (!icm_en)
      icap_armed <= 1'b0;
    else if (z_mark)
      icap_armed <= 1'b1;
    else if (quad_pulse)
      icap_armed <= 1'b0;
  end

  wire icap_take = icm_en ? (icap_armed & quad_pulse) : z_rise;
  wire acap_take = acm_en ? (dir_up ? s_rise : s_fall) : s_rise;

  // Capture storage, no reset
  always @(posedge clk_i)
  begin
    if (icap_take)
      index_capture <= position_count;
    if (acap_take)
      aux_capture <= position_count;
  end

  // ---------------------------------------------------------------
  // Event timer front end
  // ---------------------------------------------------------------
  wire div_tick, vel_event;
  wire timer_restart = wr_i & ((addr_i == `EMTR_A_DIV) | (addr_i == `EMTR_A_DECIM));

  emtr_divider #(.W(16)) u_clk_div
  (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .restart_i(timer_restart), .event_i(1'b1),
    .ratio_i(interval_clock_divider), .tick_o(div_tick)
  );

  emtr_divider #(.W(8)) u_decim
  (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .restart_i(timer_restart), .event_i(quad_pulse),
    .ratio_i(edge_decimation), .tick_o(vel_event)
  );

  assign velocity_event_o = vel_event;

  // Interval timer and hold register
  always @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      edge_interval_timer <= `EMTR_ZERO16;
      interval_hold <= `EMTR_ZERO16;
    end
    else if (timer_restart)
    begin
      edge_interval_timer <= `EMTR_ZERO16;
      interval_hold <= `EMTR_ZERO16;
    end
    else if (vel_event)
    begin
      interval_hold <= edge_interval_timer;
      edge_interval_timer <= `EMTR_ONE16;
    end
    else if (div_tick)
      edge_interval_timer <= edge_interval_timer + `EMTR_ONE16;
  end

  // ---------------------------------------------------------------
  // Register writes
  // ---------------------------------------------------------------
  always @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      encoder_control <= `EMTR_ZERO16;
      count_limit <= `EMTR_LIMIT_RST;
      limit_written <= 1'b0;
      interval_clock_divider <= `EMTR_ZERO16;
      edge_decimation <= `EMTR_ZERO8;
    end
    else if (wr_i)
    begin
      case (addr_i)
        `EMTR_A_CTRL: encoder_control <= wdata_i & `EMTR_CTRL_MASK;
        `EMTR_A_LIMIT:
        begin
          count_limit <= wdata_i;
          limit_written <= 1'b1;
        end
        `EMTR_A_DIV: interval_clock_divider <= wdata_i;
        `EMTR_A_DECIM: edge_decimation <= wdata_i[7:0];
        default: limit_written <= limit_written;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Register reads
  // ---------------------------------------------------------------
  wire [7:0] status_val;
  assign status_val[`EMTR_S_ERR] = count_err;
  assign status_val[`EMTR_S_DIR] = dir_up;
  assign status_val[`EMTR_S_UNINIT] = ~limit_written;
  assign status_val[`EMTR_S_A] = phase_a_in_i;
  assign status_val[`EMTR_S_B] = phase_b_in_i;
  assign status_val[`EMTR_S_Z] = index_marker_in_i;
  assign status_val[`EMTR_S_S] = aux_marker_in_i;
  assign status_val[`EMTR_S_FIRST] = first_seen;

  // Read data one cycle after strobe
  always @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      rdata_o <= `EMTR_ZERO16;
    else if (rd_i)
    begin
      case (addr_i)
        `EMTR_A_CTRL: rdata_o <= encoder_control;
        `EMTR_A_STAT: rdata_o <= {`EMTR_ZERO8, status_val};
        `EMTR_A_LIMIT: rdata_o <= count_limit;
        `EMTR_A_ICAP: rdata_o <= index_capture;
        `EMTR_A_ACAP: rdata_o <= aux_capture;
        `EMTR_A_DIV: rdata_o <= interval_clock_divider;
        `EMTR_A_DECIM: rdata_o <= {`EMTR_ZERO8, edge_decimation};
        `EMTR_A_COUNT: rdata_o <= position_count;
        `EMTR_A_INTVL: rdata_o <= interval_hold;
        `EMTR_A_TIMER: rdata_o <= edge_interval_timer;
        default: rdata_o <= `EMTR_ZERO16;
      endcase
    end
    else
      rdata_o <= `EMTR_ZERO16;
  end
endmodule // emtr_top

// [common/emtr_defs.vh]
// Constants for the encoder marker and event timer block.
// Assumes inclusion by bare name from the design files.
`ifndef EMTR_DEFS_VH
`define EMTR_DEFS_VH
// ---------------------------------------------------------------
// Register offsets (word addressed)
// ---------------------------------------------------------------
`define EMTR_A_CTRL 4'h0
`define EMTR_A_STAT 4'h1
`define EMTR_A_LIMIT 4'h2
`define EMTR_A_ICAP 4'h3
`define EMTR_A_ACAP 4'h4
`define EMTR_A_DIV 4'h5
`define EMTR_A_DECIM 4'h6
`define EMTR_A_COUNT 4'h7
`define EMTR_A_INTVL 4'h8
`define EMTR_A_TIMER 4'h9
// ---------------------------------------------------------------
// Control fields
// ---------------------------------------------------------------
`define EMTR_C_SWAP 0
`define EMTR_C_MRST 1
`define EMTR_C_SNM 2
`define EMTR_C_CHK 3
`define EMTR_C_ICM 7
`define EMTR_C_ACM 8
`define EMTR_CTRL_MASK 16'h018F
// ---------------------------------------------------------------
// Status fields
// ---------------------------------------------------------------
`define EMTR_S_ERR 0
`define EMTR_S_DIR 1
`define EMTR_S_UNINIT 2
`define EMTR_S_A 3
`define EMTR_S_B 4
`define EMTR_S_Z 5
`define EMTR_S_S 6
`define EMTR_S_FIRST 7
// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define EMTR_ZERO16 16'h0000
`define EMTR_ONE16 16'h0001
`define EMTR_ZERO8 8'h00
`define EMTR_ONE8 8'h01
`define EMTR_LIMIT_RST 16'hFFFF
`endif

// [verilog/emtr_edge_det.v]
// Edge detector for one filtered encoder level.
// Assumes the input is already synchronous and filtered.
module emtr_edge_det
(
  // Clock and reset
  input wire clk_i,
  input wire rst_b_i,
  // Level in, edges out
  input wire level_i,
  output wire rise_o,
  output wire fall_o
);
  reg last;

  // Previous level
  always @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      last <= 1'b0;
    else
      last <= level_i;
  end

  assign rise_o = level_i & ~last;
  assign fall_o = ~level_i & last;
endmodule // emtr_edge_det

// [verilog/emtr_divider.v]
// Modulo divider: one-cycle tick every N events, zero means maximum.
// Assumes a synchronous restart and event input.
module emtr_divider
#(
  parameter W = 16
)
(
  // Clock and reset
  input wire clk_i,
  input wire rst_b_i,
  // Control
  input wire restart_i,
  input wire event_i,
  input wire [W-1:0] ratio_i,
  output wire tick_o
);
  reg [W-1:0] cnt;
  wire [W-1:0] last_val;

  // Zero ratio wraps through the full range
  assign last_val = ratio_i - {{(W-1){1'b0}}, 1'b1};
  assign tick_o = event_i & (cnt == last_val);

  // Event counter
  always @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      cnt <= {W{1'b0}};
    else if (restart_i)
      cnt <= {W{1'b0}};
    else if (tick_o)
      cnt <= {W{1'b0}};
    else if (event_i)
      cnt <= cnt + {{(W-1){1'b0}}, 1'b1};
  end
endmodule // emtr_divider

// [sim/emtr_top_monitor.sv]
// Concurrent checks on the ports of the encoder marker and event timer.
// Assumes bind to emtr_top; one clock domain, asynchronous low reset.
module emtr_top_monitor
(
  // Clock and reset
  input wire clk_i,
  input wire rst_b_i,
  // Encoder levels
  input wire phase_a_in_i,
  input wire phase_b_in_i,
  input wire index_marker_in_i,
  input wire aux_marker_in_i,
  // Register port
  input wire [3:0] addr_i,
  input wire [15:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  input wire [15:0] rdata_o,
  // Events
  input wire count_error_o,
  input wire velocity_event_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  // Status and control read strobes
  wire st_rd = rd_i && addr_i == 4'h1;
  wire ct_rd = rd_i && addr_i == 4'h0;
  // Level bits in status track inputs held steady
  a_stat_phase_a: assert property ($past(st_rd) && $stable(phase_a_in_i) && $past(phase_a_in_i, 2) == phase_a_in_i
    |-> rdata_o[3] == phase_a_in_i) else $error("status A level wrong");
  a_stat_phase_b: assert property ($past(st_rd) && $stable(phase_b_in_i) && $past(phase_b_in_i, 2) == phase_b_in_i
    |-> rdata_o[4] == phase_b_in_i) else $error("status B level wrong");
  a_stat_index: assert property ($past(st_rd) && $stable(index_marker_in_i)
    && $past(index_marker_in_i, 2) == index_marker_in_i |-> rdata_o[5] == index_marker_in_i)
    else $error("status index level wrong");
  a_stat_aux: assert property ($past(st_rd) && $stable(aux_marker_in_i) && $past(aux_marker_in_i, 2) == aux_marker_in_i
    |-> rdata_o[6] == aux_marker_in_i) else $error("status aux level wrong");
  // Read data only after a read strobe
  a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 16'h0000) else $error("read data not idle");
  a_ctrl_unused: assert property ($past(ct_rd) |-> (rdata_o & ~16'h018f) == 16'h0000)
    else $error("unused control bits set");
  a_stat_width: assert property ($past(st_rd) |-> rdata_o[15:8] == 8'h00) else $error("status upper byte set");
  // Error event lasts one cycle
  a_error_pulse: assert property (count_error_o |=> !count_error_o) else $error("error pulse too long");
  // Main scenarios
  c_error: cover property (count_error_o);
  c_velocity: cover property (velocity_event_o);
  c_stat_read: cover property (st_rd);
endmodule // emtr_top_monitor

bind emtr_top emtr_top_monitor i_emtr_top_monitor
(
  .clk_i(clk_i), .rst_b_i(rst_b_i), .phase_a_in_i(phase_a_in_i), .phase_b_in_i(phase_b_in_i),
  .index_marker_in_i(index_marker_in_i), .aux_marker_in_i(aux_marker_in_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .count_error_o(count_error_o),
  .velocity_event_o(velocity_event_o)
);

// [sim/emtr_encoder_model.sv]
// Behavioural incremental encoder with index and auxiliary markers.
// Assumes the bench requests one step at a time on the core clock.
module emtr_encoder_model
(
  // Clock and reset
  input wire clk_i,
  input wire rst_b_i,
  // Requests
  input wire step_i,
  input wire fwd_i,
  input wire z_req_i,
  input wire s_req_i,
  // Filtered levels
  output wire phase_a_o,
  output wire phase_b_o,
  output reg index_o,
  output reg aux_o
);
  timeunit 1ns;
  timeprecision 1ps;
  reg [1:0] pos;
  // Gray order 00, 10, 11, 01 forward: A leads B
  assign phase_a_o = pos == 2'h1 || pos == 2'h2;
  assign phase_b_o = pos[1];
  // One quadrature edge per request; markers follow requests
  always @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      pos <= 2'h0;
      index_o <= 1'b0;
      aux_o <= 1'b0;
    end
    else
    begin
      if (step_i)
        pos <= fwd_i ? pos + 2'h1 : pos - 2'h1;
      index_o <= z_req_i;
      aux_o <= s_req_i;
    end
  end
endmodule // emtr_encoder_model

// [sim/emtr_top_test.sv]
// Self-checking bench for the encoder marker and event timer.
// Assumes a 20 MHz core clock and the encoder model on the far side.
module emtr_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [3:0] addr_i = 4'h0;
  logic [15:0] wdata_i = 16'h0000;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic step = 1'b0;
  logic fwd = 1'b1;
  logic z_req = 1'b0;
  logic s_req = 1'b0;
  wire pa, pb, pz, ps, count_error_o, velocity_event_o;
  wire [15:0] rdata_o;
  int n_fail = 0;
  int n_compared = 0;
  int n_err_ev = 0;
  int n_vel_ev = 0;
  emtr_top i_emtr_top (.clk_i(clk_i), .rst_b_i(rst_b_i), .phase_a_in_i(pa), .phase_b_in_i(pb),
    .index_marker_in_i(pz), .aux_marker_in_i(ps), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .count_error_o(count_error_o), .velocity_event_o(velocity_event_o));
  emtr_encoder_model i_emtr_encoder_model (.clk_i(clk_i), .rst_b_i(rst_b_i), .step_i(step), .fwd_i(fwd),
    .z_req_i(z_req), .s_req_i(s_req), .phase_a_o(pa), .phase_b_o(pb), .index_o(pz), .aux_o(ps));
  // 50 ns clock
  initial
  begin
    forever #25 clk_i = ~clk_i;
  end
  // Event counters
  always @(posedge clk_i)
  begin
    if (count_error_o === 1'b1) n_err_ev++;
    if (velocity_event_o === 1'b1) n_vel_ev++;
  end
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    chk16(rdata_o, exp);
  endtask
  // Steps four cycles apart
  task automatic move(input int n, input logic dir);
    repeat (n)
    begin
      @(posedge clk_i);
      step <= 1'b1;
      fwd <= dir;
      @(posedge clk_i);
      step <= 1'b0;
      repeat (2) @(posedge clk_i);
    end
  endtask
  task automatic mark(input logic z, input logic s);
    @(posedge clk_i);
    z_req <= z;
    s_req <= s;
    repeat (3) @(posedge clk_i);
  endtask
  task automatic conclude;
    $display("compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Hang guard
  initial
  begin
    #200us;
    n_fail++;
    conclude();
  end
  // Main sequence
  initial
  begin
    repeat (6) @(posedge clk_i);
    rst_b_i <= 1'b1;
    rd(4'h0, 16'h0000);
    rd(4'h2, 16'hffff);
    rd(4'h7, 16'h0000);
    rd(4'h1, 16'h0006);
    rd(4'hf, 16'h0000);
    wr(4'h0, 16'hffff);
    rd(4'h0, 16'h018f);
    wr(4'h0, 16'h0000);
    wr(4'h7, 16'h1234);
    rd(4'h7, 16'h0000);
    $display("test reset done");
    wr(4'h2, 16'h0007);
    rd(4'h1, 16'h0002);
    move(3, 1'b1);
    rd(4'h7, 16'h0003);
    move(4, 1'b0);
    rd(4'h7, 16'h0007);
    rd(4'h1, 16'h0010);
    move(1, 1'b1);
    rd(4'h7, 16'h0000);
    $display("test rollover done");
    move(2, 1'b1);
    mark(1'b0, 1'b1);
    rd(4'h4, 16'h0002);
    rd(4'h1, 16'h005a);
    mark(1'b0, 1'b0);
    mark(1'b1, 1'b0);
    rd(4'h3, 16'h0002);
    mark(1'b0, 1'b0);
    wr(4'h0, 16'h0180);
    move(1, 1'b0);
    mark(1'b0, 1'b1);
    rd(4'h4, 16'h0002);
    mark(1'b0, 1'b0);
    rd(4'h4, 16'h0001);
    mark(1'b1, 1'b0);
    mark(1'b0, 1'b0);
    rd(4'h3, 16'h0002);
    move(1, 1'b0);
    rd(4'h3, 16'h0001);
    move(2, 1'b1);
    $display("test capture done");
    wr(4'h0, 16'h000a);
    mark(1'b1, 1'b0);
    rd(4'h7, 16'h0002);
    move(1, 1'b1);
    rd(4'h7, 16'h0000);
    mark(1'b0, 1'b0);
    rd(4'h1, 16'h0093);
    chk16(16'(n_err_ev), 16'h0001);
    mark(1'b1, 1'b0);
    rd(4'h1, 16'h00b2);
    mark(1'b0, 1'b0);
    move(3, 1'b1);
    rd(4'h7, 16'h0003);
    $display("test marker done");
    wr(4'h0, 16'h0000);
    wr(4'h5, 16'h0001);
    wr(4'h6, 16'h0002);
    n_vel_ev = 0;
    move(4, 1'b1);
    chk16(16'(n_vel_ev), 16'h0002);
    rd(4'h8, 16'h0008);
    $display("test interval done");
    @(posedge clk_i);
    rst_b_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    rst_b_i <= 1'b1;
    rd(4'h1, 16'h0006);
    wr(4'h2, 16'h0007);
    wr(4'h0, 16'h0006);
    move(2, 1'b1);
    mark(1'b1, 1'b0);
    move(1, 1'b1);
    rd(4'h7, 16'h0000);
    mark(1'b0, 1'b0);
    mark(1'b1, 1'b0);
    move(4, 1'b1);
    rd(4'h7, 16'h0004);
    $display("test single marker done");
    conclude();
  end
endmodule // emtr_top_test
